//--- shared/tcc_pkg.sv
// Package: register map, field positions, reset values and timing constants for the timer
// What this block does
// R1 - High-byte location accesses go to the shared staging byte, never counter directly; compare high-byte reads here return the compare register directly.
// R2 - Reading counter low byte loads counter upper byte into staging byte same cycle.
// R3 - Writing counter low byte loads staging byte and written byte together.
// R4 - Host may write one shared upper byte once, then several low bytes.
// R5 - Host masks interrupts across both byte accesses when handlers share staging.
// R6 - Three-bit clock select in control B picks source; zero stops the counter.
// R7 - Counter stays CPU readable and writable with or without timer clock.
// R8 - CPU counter write beats clear, increment or decrement in the same cycle.
// R9 - Each timer clock enable clears, increments or decrements by one per mode.
// R10 - Counting sequence follows four-bit waveform mode split over control A and B.
// R11 - Overflow flag sets where the mode says and can raise an interrupt.
// R12 - Counter gives top indication at sequence maximum, bottom indication at zero.
// R13 - Capture trigger is the capture pin or, alternatively, the comparator output.
// R14 - Selected edge on trigger copies the full counter into the capture register.
// R15 - Capture flag sets in the same cycle the capture register is loaded.
// R16 - Capture flag with interrupt enable set raises the capture interrupt request.
// R17 - Capture flag clears on interrupt service or writing one; zero leaves it.
// R18 - Capture low read copies captured upper byte to staging for the high read.
// R19 - Capture register writable only in modes that use it as top.
// R20 - Host writes capture upper byte location first, then the lower byte.
// R21 - One staging byte serves counter, three compare registers and capture register.
// R22 - Comparator capture select switches the trigger from pin to comparator output.
// R23 - Noise filter output changes only after four equal consecutive system-clock samples.
// R24 - Enabled noise filter adds four system clock cycles, independent of prescaler.
// R25 - Edge select bit: set captures rising edge, clear captures falling edge.
package tcc_pkg;
  // I/O addresses are local to the timer; the enclosing core maps them
  localparam logic [3:0] ADDR_CTRL_A     = 4'h0;
  localparam logic [3:0] ADDR_CTRL_B     = 4'h1;
  localparam logic [3:0] ADDR_CNT_LO     = 4'h4;
  localparam logic [3:0] ADDR_CNT_HI     = 4'h5;
  localparam logic [3:0] ADDR_CAP_LO     = 4'h6;
  localparam logic [3:0] ADDR_CAP_HI     = 4'h7;
  localparam logic [3:0] ADDR_CMPA_LO    = 4'h8;
  localparam logic [3:0] ADDR_CMPA_HI    = 4'h9;
  localparam logic [3:0] ADDR_CMPB_LO    = 4'hA;
  localparam logic [3:0] ADDR_CMPB_HI    = 4'hB;
  localparam logic [3:0] ADDR_CMPC_LO    = 4'hC;
  localparam logic [3:0] ADDR_CMPC_HI    = 4'hD;
  localparam logic [3:0] ADDR_FLAGS      = 4'hE;
  localparam logic [3:0] ADDR_MASK       = 4'hF;
  // Field positions
  localparam int CTRLB_FILTER_BIT = 7;
  localparam int CTRLB_EDGE_BIT   = 6;
  localparam int CTRLB_WGM_HI_LSB = 3;
  localparam int FLAG_OVF_BIT     = 0;
  localparam int FLAG_CAP_BIT     = 5;
  // Reset values
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  // Fixed top values and limits
  localparam logic [15:0] TOP_8BIT    = 16'h00FF;
  localparam logic [15:0] TOP_9BIT    = 16'h01FF;
  localparam logic [15:0] TOP_10BIT   = 16'h03FF;
  localparam logic [15:0] TOP_MAX     = 16'hFFFF;
  localparam logic [15:0] BOTTOM_VAL  = 16'h0000;
  // Noise filter sample count
  localparam int FILTER_SAMPLES = 4;
endpackage

//--- src/tcc_noise_filter.sv
// Four-sample majority-free noise filter and edge detector for the capture trigger
module tcc_noise_filter
  import tcc_pkg::*;
#(
  parameter int SAMPLES = FILTER_SAMPLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic enable,
  input  wire logic filter_on,
  input  wire logic rising_sel,
  // Trigger
  input  wire logic trig_in,
  output logic      edge_hit
);
  logic [SAMPLES-1:0] hist;
  logic [SAMPLES-1:0] next_hist;
  logic               filt;
  logic               prev;
  logic               cur;

  // Judge the window including this sample, so the delay is exactly SAMPLES cycles
  assign next_hist = {hist[SAMPLES-2:0], trig_in};

  // R23 four equal samples
  always_ff @(posedge clk) begin
    if (reset) begin
      hist <= '0;
      filt <= 1'b0;
    end else begin
      hist <= next_hist;
      if (&next_hist)
        filt <= 1'b1;
      else if (~|next_hist)
        filt <= 1'b0;
    end
  end

  // R24 filter adds delay
  assign cur = filter_on ? filt : trig_in;

  always_ff @(posedge clk) begin
    if (reset)
      prev <= 1'b0;
    else
      prev <= cur;
  end

  // R25 edge polarity select
  assign edge_hit = enable & (rising_sel ? (cur & ~prev) : (~cur & prev));
endmodule

//--- src/tcc_counter.sv
// 16-bit up/down counter with mode-dependent top, clear and overflow event
module tcc_counter
  import tcc_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Control
  input  wire logic             tick,
  input  wire logic [3:0]       mode,
  input  wire logic [WIDTH-1:0] top_val,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_val,
  // State
  output logic      [WIDTH-1:0] count,
  output logic                  at_top,
  output logic                  at_bottom,
  output logic                  ovf_event
);
  logic down;
  logic dual;
  logic ctc;

  // R10 mode decode
  assign dual = (mode inside {4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11});
  assign ctc  = (mode == 4'd4) || (mode == 4'd12);
  // R12 top and bottom
  assign at_top    = (count == top_val);
  assign at_bottom = (count == BOTTOM_VAL);

  // R8 write wins; R9 count step
  always_ff @(posedge clk) begin
    if (reset) begin
      count <= WORD_RESET;
      down  <= 1'b0;
    end else if (wr_en) begin
      count <= wr_val;
    end else if (tick) begin
      if (dual) begin
        if (at_top) begin
          down  <= 1'b1;
          count <= count - 16'h0001;
        end else if (down && !at_bottom) begin
          count <= count - 16'h0001;
        end else begin
          down  <= 1'b0;
          count <= count + 16'h0001;
        end
      end else if (at_top && (ctc || mode != 4'd0)) begin
        count <= BOTTOM_VAL;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // R11 overflow point per mode
  always_comb begin
    if (!tick || wr_en)
      ovf_event = 1'b0;
    else if (dual)
      ovf_event = at_bottom && down;
    else if (mode == 4'd0)
      ovf_event = (count == TOP_MAX);
    else if (ctc)
      ovf_event = (count == TOP_MAX);
    else
      ovf_event = at_top;
  end
endmodule

//--- src/tcc_timer16.sv
// Top of the 16-bit timer: I/O register file, staging byte, clock select and capture unit
module tcc_timer16
  import tcc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // CPU I/O bus
  input  wire logic [3:0] io_addr,
  input  wire logic       io_rd,
  input  wire logic       io_wr,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Prescaler taps and external clock enable
  input  wire logic [4:0] presc_tick,
  input  wire logic       ext_fall_tick,
  input  wire logic       ext_rise_tick,
  // Capture sources
  input  wire logic       capture_input_pin,
  input  wire logic       comparator_output,
  input  wire logic       comparator_capture_select,
  // Interrupt service acknowledge
  input  wire logic       ovf_irq_ack,
  input  wire logic       cap_irq_ack,
  // Interrupt requests
  output logic            ovf_irq,
  output logic            cap_irq,
  // Waveform interface
  output logic [15:0]     count_value,
  output logic            top_hit,
  output logic            bottom_hit,
  output logic [15:0]     compare_a,
  output logic [15:0]     compare_b,
  output logic [15:0]     compare_c
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [7:0]  control_reg_a;
  logic [7:0]  control_reg_b;
  logic [7:0]  staging;
  logic [15:0] capture_value;
  logic [15:0] cmp_a;
  logic [15:0] cmp_b;
  logic [15:0] cmp_c;
  logic        overflow_flag;
  logic        capture_flag;
  logic        ovf_irq_enable;
  logic        capture_irq_enable;
  logic [2:0]  clock_source_select;
  logic [3:0]  waveform_mode_select;
  logic        timer_clock_enable;
  logic [15:0] count;
  logic [15:0] top_val;
  logic        at_top;
  logic        at_bottom;
  logic        ovf_event;
  logic        cnt_wr;
  logic        cap_top_mode;
  logic        trig;
  logic        cap_event;
  logic        rd_cnt_lo;
  logic        rd_cap_lo;

  assign clock_source_select  = control_reg_b[2:0];
  // R10 mode split A and B
  assign waveform_mode_select = {control_reg_b[CTRLB_WGM_HI_LSB+1:CTRLB_WGM_HI_LSB],
                                 control_reg_a[1:0]};

  ////////////////////////////////////////////////////////////////////////////////
  // R6 clock source select
  always_comb begin
    case (clock_source_select)
      3'd0:    timer_clock_enable = 1'b0;
      3'd1:    timer_clock_enable = presc_tick[0];
      3'd2:    timer_clock_enable = presc_tick[1];
      3'd3:    timer_clock_enable = presc_tick[2];
      3'd4:    timer_clock_enable = presc_tick[3];
      3'd5:    timer_clock_enable = presc_tick[4];
      3'd6:    timer_clock_enable = ext_fall_tick;
      default: timer_clock_enable = ext_rise_tick;
    endcase
  end

  // Top value per mode; capture-as-top modes are 8, 10, 12, 14
  assign cap_top_mode = (waveform_mode_select == 4'd8) || (waveform_mode_select == 4'd10) ||
                        (waveform_mode_select == 4'd12) || (waveform_mode_select == 4'd14);

  always_comb begin
    case (waveform_mode_select)
      4'd1, 4'd5:          top_val = TOP_8BIT;
      4'd2, 4'd6:          top_val = TOP_9BIT;
      4'd3, 4'd7:          top_val = TOP_10BIT;
      4'd4, 4'd9, 4'd11,
      4'd15:               top_val = cmp_a;
      4'd8, 4'd10, 4'd12,
      4'd14:               top_val = capture_value;
      default:             top_val = TOP_MAX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // R3 low write commits word; R7 access any time
  assign cnt_wr    = io_wr && (io_addr == ADDR_CNT_LO);
  assign rd_cnt_lo = io_rd && (io_addr == ADDR_CNT_LO);
  assign rd_cap_lo = io_rd && (io_addr == ADDR_CAP_LO);

  tcc_counter #(
    .WIDTH (16)
  ) u_counter (
    .clk       (clk),
    .reset     (reset),
    .tick      (timer_clock_enable),
    .mode      (waveform_mode_select),
    .top_val   (top_val),
    .wr_en     (cnt_wr),
    .wr_val    ({staging, io_wdata}),
    .count     (count),
    .at_top    (at_top),
    .at_bottom (at_bottom),
    .ovf_event (ovf_event)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // R21 one staging byte for all words
  always_ff @(posedge clk) begin
    if (reset)
      staging <= CTRL_RESET;
    else if (rd_cnt_lo)
      // R2 latch counter upper byte
      staging <= count[15:8];
    else if (rd_cap_lo)
      // R18 latch captured upper byte
      staging <= capture_value[15:8];
    // R1 high locations hit staging only
    else if (io_wr && (io_addr inside {ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMPA_HI,
                                      ADDR_CMPB_HI, ADDR_CMPC_HI}))
      staging <= io_wdata;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      control_reg_a <= CTRL_RESET;
      control_reg_b <= CTRL_RESET;
    end else if (io_wr && io_addr == ADDR_CTRL_A) begin
      control_reg_a <= io_wdata;
    end else if (io_wr && io_addr == ADDR_CTRL_B) begin
      control_reg_b <= io_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cmp_a <= WORD_RESET;
      cmp_b <= WORD_RESET;
      cmp_c <= WORD_RESET;
    end else if (io_wr) begin
      // Compare words are held directly; double buffering lives in the waveform logic
      case (io_addr)
        ADDR_CMPA_LO: cmp_a <= {staging, io_wdata};
        ADDR_CMPB_LO: cmp_b <= {staging, io_wdata};
        ADDR_CMPC_LO: cmp_c <= {staging, io_wdata};
        default:      ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ovf_irq_enable     <= 1'b0;
      capture_irq_enable <= 1'b0;
    end else if (io_wr && io_addr == ADDR_MASK) begin
      ovf_irq_enable     <= io_wdata[FLAG_OVF_BIT];
      capture_irq_enable <= io_wdata[FLAG_CAP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // R13 R22 trigger source select
  assign trig = comparator_capture_select ? comparator_output : capture_input_pin;

  // Capture input is idle while the capture word defines top
  tcc_noise_filter #(
    .SAMPLES (FILTER_SAMPLES)
  ) u_filter (
    .clk        (clk),
    .reset      (reset),
    .enable     (!cap_top_mode),
    .filter_on  (control_reg_b[CTRLB_FILTER_BIT]),
    .rising_sel (control_reg_b[CTRLB_EDGE_BIT]),
    .trig_in    (trig),
    .edge_hit   (cap_event)
  );

  // R14 capture counter; R19 writes only in top modes
  always_ff @(posedge clk) begin
    if (reset)
      capture_value <= WORD_RESET;
    else if (cap_event)
      capture_value <= count;
    else if (io_wr && io_addr == ADDR_CAP_LO && cap_top_mode)
      capture_value <= {staging, io_wdata};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // R15 flag with capture; R17 clear by ack or one; set wins
  always_ff @(posedge clk) begin
    if (reset)
      capture_flag <= 1'b0;
    else if (cap_event)
      capture_flag <= 1'b1;
    else if (cap_irq_ack || (io_wr && io_addr == ADDR_FLAGS && io_wdata[FLAG_CAP_BIT]))
      capture_flag <= 1'b0;
  end

  // R11 overflow flag; set wins
  always_ff @(posedge clk) begin
    if (reset)
      overflow_flag <= 1'b0;
    else if (ovf_event)
      overflow_flag <= 1'b1;
    else if (ovf_irq_ack || (io_wr && io_addr == ADDR_FLAGS && io_wdata[FLAG_OVF_BIT]))
      overflow_flag <= 1'b0;
  end

  // R16 capture request
  always_ff @(posedge clk) begin
    if (reset) begin
      cap_irq <= 1'b0;
      ovf_irq <= 1'b0;
    end else begin
      cap_irq <= (capture_flag || cap_event) && capture_irq_enable;
      ovf_irq <= (overflow_flag || ovf_event) && ovf_irq_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered read data, valid the cycle after io_rd
  always_ff @(posedge clk) begin
    if (reset) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        ADDR_CTRL_A:  io_rdata <= control_reg_a;
        ADDR_CTRL_B:  io_rdata <= control_reg_b;
        ADDR_CNT_LO:  io_rdata <= count[7:0];
        ADDR_CAP_LO:  io_rdata <= capture_value[7:0];
        ADDR_CNT_HI,
        ADDR_CAP_HI:  io_rdata <= staging;
        ADDR_CMPA_LO: io_rdata <= cmp_a[7:0];
        ADDR_CMPA_HI: io_rdata <= cmp_a[15:8];
        ADDR_CMPB_LO: io_rdata <= cmp_b[7:0];
        ADDR_CMPB_HI: io_rdata <= cmp_b[15:8];
        ADDR_CMPC_LO: io_rdata <= cmp_c[7:0];
        ADDR_CMPC_HI: io_rdata <= cmp_c[15:8];
        ADDR_FLAGS:   io_rdata <= {2'b00, capture_flag, 4'h0, overflow_flag};
        ADDR_MASK:    io_rdata <= {2'b00, capture_irq_enable, 4'h0, ovf_irq_enable};
        default:      io_rdata <= 8'h00;
      endcase
    end
  end

  // R12 waveform outputs, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      count_value <= WORD_RESET;
      top_hit     <= 1'b0;
      bottom_hit  <= 1'b0;
      compare_a   <= WORD_RESET;
      compare_b   <= WORD_RESET;
      compare_c   <= WORD_RESET;
    end else begin
      count_value <= count;
      top_hit     <= at_top;
      bottom_hit  <= at_bottom;
      compare_a   <= cmp_a;
      compare_b   <= cmp_b;
      compare_c   <= cmp_c;
    end
  end
endmodule

//--- dv/tcc_timer16_props.sv
// Checker for the timer's bus, counter and interrupt outputs
module tcc_timer16_props
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // CPU I/O bus
  input wire logic [3:0]  io_addr,
  input wire logic        io_rd,
  input wire logic        io_wr,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  // Watched outputs
  input wire logic        ovf_irq,
  input wire logic        cap_irq,
  input wire logic [15:0] count_value,
  input wire logic        bottom_hit,
  input wire logic [15:0] compare_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] stage;
  logic       stage_ok;
  logic [2:0] clk_sel;
  logic       wr_hi;
  assign wr_hi = io_wr && (io_addr inside {ADDR_CNT_HI, ADDR_CAP_HI, ADDR_CMPA_HI,
                                           ADDR_CMPB_HI, ADDR_CMPC_HI});
  ////////////////////////////////////////////////////////////////////////////////
  // Staging mirror is only trusted until a low read reloads it from the counter or capture register
  always_ff @(posedge clk) begin
    if (reset) begin
      stage    <= 8'h00;
      stage_ok <= 1'b0;
    end else if (wr_hi) begin
      stage    <= io_wdata;
      stage_ok <= 1'b1;
    end else if (io_rd && (io_addr inside {ADDR_CNT_LO, ADDR_CAP_LO})) begin
      stage_ok <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_sel <= 3'h0;
    end else if (io_wr && io_addr == ADDR_CTRL_B) begin
      clk_sel <= io_wdata[2:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  unmapped_read_a: assert property (io_rd && io_addr inside {4'h2, 4'h3}
    |=> io_rdata == 8'h00) else $error("unmapped read not zero");
  cnt_write_a: assert property (io_wr && io_addr == ADDR_CNT_LO && stage_ok
    |-> ##2 count_value == {$past(stage, 2), $past(io_wdata, 2)}) else $error("counter write");
  cnt_low_a: assert property (io_rd && io_addr == ADDR_CNT_LO
    |=> io_rdata == count_value[7:0]) else $error("counter low read");
  cnt_high_a: assert property ((io_rd && io_addr == ADDR_CNT_LO) ##1 (!io_rd && !io_wr)
    ##1 (io_rd && io_addr == ADDR_CNT_HI) |=> io_rdata == $past(count_value[15:8], 2))
    else $error("counter high read");
  stopped_hold_a: assert property (clk_sel == 3'h0 && !(io_wr && io_addr == ADDR_CNT_LO)
    |=> ##1 $stable(count_value)) else $error("stopped counter moved");
  ovf_mask_a: assert property (io_wr && io_addr == ADDR_MASK && !io_wdata[FLAG_OVF_BIT]
    |-> ##2 !ovf_irq) else $error("masked overflow request");
  cap_mask_a: assert property (io_wr && io_addr == ADDR_MASK && !io_wdata[FLAG_CAP_BIT]
    |-> ##2 !cap_irq) else $error("masked capture request");
  bottom_flag_a: assert property (!$past(reset)
    |-> bottom_hit == (count_value == BOTTOM_VAL)) else $error("bottom flag");
  cmp_write_a: assert property (io_wr && io_addr == ADDR_CMPA_LO && stage_ok
    |-> ##2 compare_a == {$past(stage, 2), $past(io_wdata, 2)}) else $error("compare write");
endmodule

bind tcc_timer16 tcc_timer16_props props_i (
  .clk, .reset, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
  .ovf_irq, .cap_irq, .count_value, .bottom_hit, .compare_a
);

//--- dv/tcc_cpu_model.sv
// CPU side of the I/O bus: byte and 16-bit register accesses
module tcc_cpu_model
  import tcc_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // I/O bus
  output logic      [3:0] io_addr,
  output logic            io_rd,
  output logic            io_wr,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    io_addr  = 4'h0;
    io_rd    = 1'b0;
    io_wr    = 1'b0;
    io_wdata = 8'h00;
  end
  // single byte writes let one upper byte serve several words
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk);
    io_wr    <= 1'b0;
    io_addr  <= ~a;
    io_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk);
    io_rd   <= 1'b0;
    io_addr <= ~a;
    #1;
    d = io_rdata;
  endtask
  // upper byte first, nothing else touches staging in between
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    wr(lo + 4'h1, v[15:8]);
    wr(lo, v[7:0]);
  endtask
  // lower byte first so the upper byte comes from staging
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    rd(lo, v[7:0]);
    rd(lo + 4'h1, v[15:8]);
  endtask
endmodule

//--- dv/tb_timer16_counter_capture.sv
// Self-checking bench for the 16-bit timer with capture
module tb_timer16_counter_capture
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [4:0]  presc_tick = 5'h00;
  logic        ext_fall_tick = 1'b0;
  logic        ext_rise_tick = 1'b0;
  logic        capture_input_pin = 1'b0;
  logic        comparator_output = 1'b0;
  logic        comparator_capture_select = 1'b0;
  logic        ovf_irq_ack = 1'b0;
  logic        cap_irq_ack = 1'b0;
  logic [3:0]  io_addr;
  logic        io_rd, io_wr, ovf_irq, cap_irq, top_hit, bottom_hit;
  logic [7:0]  io_wdata, io_rdata, d;
  logic [15:0] count_value, compare_a, compare_b, compare_c, w;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  tcc_cpu_model cpu (.clk, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata);
  tcc_timer16 dut (.clk, .reset, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata,
    .presc_tick, .ext_fall_tick, .ext_rise_tick, .capture_input_pin, .comparator_output,
    .comparator_capture_select, .ovf_irq_ack, .cap_irq_ack, .ovf_irq, .cap_irq,
    .count_value, .top_hit, .bottom_hit, .compare_a, .compare_b, .compare_c);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Sources 1..5 are prescaler taps, 6 and 7 the external edges
  task automatic tick(input int sel, input int k);
    repeat (k) begin
      @(posedge clk);
      presc_tick    <= 5'((1 << sel) >> 1);
      ext_fall_tick <= (sel == 6);
      ext_rise_tick <= (sel == 7);
      @(posedge clk);
      presc_tick    <= 5'h00;
      ext_fall_tick <= 1'b0;
      ext_rise_tick <= 1'b0;
    end
  endtask
  task automatic drive(input logic comp, input logic v);
    @(posedge clk);
    if (comp) begin
      comparator_output <= v;
    end else begin
      capture_input_pin <= v;
    end
  endtask
  task automatic cap_wait(input int exp);
    int n;
    n = 0;
    while (cap_irq !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("capture latency", 16'(n), 16'(exp));
  endtask
  task automatic ack(input logic cap);
    @(posedge clk);
    if (cap) cap_irq_ack <= 1'b1;
    else ovf_irq_ack <= 1'b1;
    @(posedge clk);
    cap_irq_ack <= 1'b0;
    ovf_irq_ack <= 1'b0;
    wait_n(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_staging();
    for (int a = 0; a < 16; a++) begin
      cpu.rd(4'(a), d);
      check("reset value", 16'(d), 16'h0000);
    end
    cpu.wr16(ADDR_CNT_LO, 16'h12AB);
    cpu.wr(ADDR_CNT_HI, 8'h55);
    cpu.rd(ADDR_CNT_HI, d);
    check("staging read", 16'(d), 16'h0055);
    cpu.rd16(ADDR_CNT_LO, w);
    check("counter word", w, 16'h12AB);
    cpu.wr(ADDR_CNT_HI, 8'h34);
    cpu.wr(ADDR_CNT_LO, 8'h56);
    cpu.wr(ADDR_CMPA_LO, 8'h78);
    cpu.wr(ADDR_CMPB_LO, 8'h9A);
    cpu.wr(ADDR_CMPC_LO, 8'hBC);
    wait_n(2);
    check("counter", count_value, 16'h3456);
    check("compare a", compare_a, 16'h3478);
    check("compare b", compare_b, 16'h349A);
    check("compare c", compare_c, 16'h34BC);
  endtask
  task automatic t_counting();
    for (int s = 1; s < 8; s++) begin
      cpu.wr(ADDR_CTRL_B, 8'(s));
      cpu.wr16(ADDR_CNT_LO, 16'h0000);
      tick(s, 3);
      wait_n(2);
      check("count per source", count_value, 16'h0003);
    end
    cpu.wr(ADDR_CTRL_B, 8'h00);
    tick(1, 2);
    wait_n(2);
    check("stopped", count_value, 16'h0003);
    cpu.wr(ADDR_CTRL_B, 8'h01);
    cpu.wr(ADDR_CNT_HI, 8'h10);
    fork
      cpu.wr(ADDR_CNT_LO, 8'h00);
      tick(1, 1);
    join
    wait_n(2);
    check("write beats tick", count_value, 16'h1000);
    cpu.wr(ADDR_CTRL_A, 8'h01);
    cpu.wr16(ADDR_CNT_LO, 16'h00FE);
    tick(1, 1);
    wait_n(2);
    check("up to top", count_value, 16'h00FF);
    check("top flag", 16'(top_hit), 16'h0001);
    tick(1, 1);
    wait_n(2);
    check("down from top", count_value, 16'h00FE);
    cpu.wr(ADDR_CTRL_A, 8'h00);
    cpu.wr(ADDR_MASK, 8'h01);
    cpu.wr16(ADDR_CNT_LO, 16'hFFFF);
    tick(1, 1);
    wait_n(3);
    check("wrap", count_value, 16'h0000);
    check("bottom flag", 16'(bottom_hit), 16'h0001);
    check("overflow request", 16'(ovf_irq), 16'h0001);
    cpu.rd(ADDR_FLAGS, d);
    check("overflow flag", 16'(d[FLAG_OVF_BIT]), 16'h0001);
    ack(1'b0);
    check("overflow serviced", 16'(ovf_irq), 16'h0000);
    cpu.wr(ADDR_CTRL_B, 8'h00);
  endtask
  task automatic t_capture();
    cpu.wr(ADDR_CTRL_B, 8'h40);
    cpu.wr16(ADDR_CNT_LO, 16'h2345);
    cpu.wr(ADDR_MASK, 8'h20);
    drive(1'b0, 1'b1);
    cap_wait(1);
    cpu.rd16(ADDR_CAP_LO, w);
    check("captured word", w, 16'h2345);
    cpu.wr(ADDR_FLAGS, 8'h00);
    wait_n(2);
    check("flag kept", 16'(cap_irq), 16'h0001);
    cpu.wr(ADDR_FLAGS, 8'h20);
    wait_n(2);
    check("flag cleared", 16'(cap_irq), 16'h0000);
    cpu.wr16(ADDR_CNT_LO, 16'h3000);
    drive(1'b0, 1'b0);
    wait_n(8);
    check("wrong edge", 16'(cap_irq), 16'h0000);
    cpu.wr(ADDR_CTRL_B, 8'h00);
    drive(1'b0, 1'b1);
    drive(1'b0, 1'b0);
    cap_wait(1);
    cpu.rd16(ADDR_CAP_LO, w);
    check("falling capture", w, 16'h3000);
    ack(1'b1);
    check("capture serviced", 16'(cap_irq), 16'h0000);
    cpu.wr(ADDR_CTRL_B, 8'h40);
    @(posedge clk);
    comparator_capture_select <= 1'b1;
    cpu.wr16(ADDR_CNT_LO, 16'h4000);
    drive(1'b0, 1'b1);
    wait_n(8);
    check("pin ignored", 16'(cap_irq), 16'h0000);
    drive(1'b1, 1'b1);
    cap_wait(1);
    cpu.rd16(ADDR_CAP_LO, w);
    check("comparator capture", w, 16'h4000);
    @(posedge clk);
    comparator_capture_select <= 1'b0;
    cpu.wr(ADDR_CTRL_B, 8'hC0);
    cpu.wr(ADDR_FLAGS, 8'h20);
    drive(1'b0, 1'b0);
    wait_n(10);
    cpu.wr16(ADDR_CNT_LO, 16'h5000);
    drive(1'b0, 1'b1);
    wait_n(2);
    drive(1'b0, 1'b0);
    wait_n(10);
    check("short pulse filtered", 16'(cap_irq), 16'h0000);
    drive(1'b0, 1'b1);
    cap_wait(1 + FILTER_SAMPLES);
    cpu.wr(ADDR_MASK, 8'h00);
    cpu.rd(ADDR_FLAGS, d);
    check("capture flag held", 16'(d[FLAG_CAP_BIT]), 16'h0001);
    check("capture masked", 16'(cap_irq), 16'h0000);
    // Host selects a capture-as-top mode before writing the top value
    cpu.wr(ADDR_CTRL_B, 8'h00);
    cpu.wr16(ADDR_CAP_LO, 16'h1111);
    cpu.rd16(ADDR_CAP_LO, w);
    check("capture write refused", w, 16'h5000);
    cpu.wr(ADDR_CTRL_B, 8'h18);
    cpu.wr16(ADDR_CAP_LO, 16'h0100);
    cpu.rd16(ADDR_CAP_LO, w);
    check("capture top write", w, 16'h0100);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Whole run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset_and_staging();
    t_counting();
    t_capture();
    report_and_stop();
  end
endmodule
